// ---- design/gdt_slave.v ----
/*
  two-wire slave front end of a 12-channel 10-bit reference generator.
  holds: pin synchronisers and start/stop detection, the byte engine that
  shifts address, channel and data bytes in and read bytes out, address
  match with the strap pin, hs-mode entry on the master code and exit at
  stop, general call reset, and the two-stage channel bank (preload and
  output) with latch-pin and latch-all-bit transfer.
  also holds the small two-flop synchroniser used for every pin.
  assumes scl/sda arrive from outside the 100 mhz clock domain and that the
  bench resolves the open-drain sda wire from o_sda_oe.
  assumes scl low and high phases each last several system clocks, since
  every bus edge is seen two to three clocks late through the synchronisers.
  limitation: the channel bank lives in flops, so its reset values are fixed
  at build time; a general call rebuilds them exactly like power-up.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gdt_regs.vh"

module gdt_slave #(
  parameter NCH = 12
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_scl,
  input wire i_sda,
  input wire i_addr_select_pin,
  input wire i_latch_hold_pin,
  output reg o_sda_oe,
  output reg o_hs_mode,
  output reg [NCH*10-1:0] o_level
);

  // byte engine states: idle between frames, then one state per byte kind.
  // ignore swallows the rest of a frame that is not ours or was refused,
  // so nothing is acked until the next start or stop.
  // rdata also covers the master's ack bit between read bytes.
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_GCALL = 3'h5;
  localparam ST_IGNORE = 3'h6;

  // pin synchronisers; the bus lines reset to their released high level so
  // that no false start or stop is seen right after reset
  wire scl;
  wire sda;
  wire latch_hold_sync;
  wire addr_sel_sync;

  gdt_sync2 #(
    .RST_VAL(1'b1)
  ) u_sync_scl (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_scl),
    .o_sync(scl)
  );

  gdt_sync2 #(
    .RST_VAL(1'b1)
  ) u_sync_sda (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_sda),
    .o_sync(sda)
  );

  gdt_sync2 #(
    .RST_VAL(1'b0)
  ) u_sync_latch (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_latch_hold_pin),
    .o_sync(latch_hold_sync)
  );

  gdt_sync2 #(
    .RST_VAL(1'b0)
  ) u_sync_asel (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_addr_select_pin),
    .o_sync(addr_sel_sync)
  );

  // one history stage behind the synchronised bus lines for edge finding
  reg scl_d;
  reg sda_d;
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  // sda moving while scl stays high is framing, never data
  wire start_det = scl & scl_d & sda_d & ~sda;
  wire stop_det = scl & scl_d & ~sda_d & sda;

  // byte engine: frame state, bit count and the shared shift register
  reg [2:0] state;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  // write side: high half of a word waits here until the low half lands
  reg [7:0] upper;
  reg have_upper;
  // channel pointer, shared by writes and reads
  reg [3:0] chan;
  // ninth clock of a byte: ack from us on writes, from the master on reads
  reg ack_phase;
  reg master_ack;
  // read side: queued byte and which half of the word the queued byte holds
  reg [7:0] tx_byte;
  reg tx_low;
  // first stage of every channel; the output stage is o_level itself
  reg [NCH*10-1:0] preload;
  // one-clock pulse that replays the power-up reset after a general call
  reg gcall_rst;

  // reset codes, channel a in the low slice
  wire [NCH*10-1:0] rst_codes = {`GDT_RST_L, `GDT_RST_K, `GDT_RST_J, `GDT_RST_I, `GDT_RST_H, `GDT_RST_G,
    `GDT_RST_F, `GDT_RST_E, `GDT_RST_D, `GDT_RST_C, `GDT_RST_B, `GDT_RST_A};

  // bit capture: the rise path shifts in rx_next; the byte decode at the
  // fall reads the settled shift register, never the live line, because
  // by then sda may already carry the next bit or the ack
  wire [7:0] rx_next = {shreg[6:0], sda};
  wire [7:0] rx_byte = shreg;
  wire [6:0] own_addr = {`GDT_ADDR_BASE, addr_sel_sync};
  wire [9:0] sel_code = preload[chan*10 +: 10];
  wire chan_ok = (chan <= `GDT_CHAN_LAST);

  // address byte classes, decoded once from the captured byte
  wire is_master_code = (rx_byte[7:3] == `GDT_HS_CODE_TOP);
  wire is_gcall = (rx_byte == `GDT_GCALL_ADDR);
  wire is_own = (rx_byte[7:1] == own_addr);
  wire is_read = rx_byte[0];
  // channel byte: high nibble must be clear and the index in range
  wire chan_byte_ok = (rx_byte[7:4] == 4'h0) && (rx_byte[3:0] <= `GDT_CHAN_LAST);
  // the ten-bit word completed by the low byte; bits above d9 are dropped
  wire [9:0] wr_code = {upper[1:0], rx_byte};
  wire latch_all = upper[`GDT_LATCH_ALL_BIT-8];

  // read pointer after a finished word; wraps after the last channel
  reg [3:0] next_chan;
  always @* begin
    next_chan = chan + 4'h1;
    if (chan >= `GDT_CHAN_LAST)
      next_chan = 4'h0;
  end

  // read word: code right-aligned, high bits zero
  wire [7:0] rd_hi = {6'h00, sel_code[9:8]};
  wire [7:0] rd_lo = sel_code[7:0];
  // high half of the following channel, queued as a word ends
  wire [9:0] nxt_code = preload[next_chan*10 +: 10];
  wire [7:0] nxt_hi = {6'h00, nxt_code[9:8]};

  // byte engine: sample on scl rise, act on scl fall
  always @(posedge i_clk) begin
    if (!i_reset_n || gcall_rst) begin
      // power-up and general call share this path
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      upper <= 8'h00;
      have_upper <= 1'b0;
      chan <= 4'h0;
      ack_phase <= 1'b0;
      tx_byte <= 8'h00;
      tx_low <= 1'b0;
      master_ack <= 1'b0;
      o_sda_oe <= 1'b0;
      o_hs_mode <= 1'b0;
      preload <= rst_codes;
      o_level <= rst_codes;
      gcall_rst <= 1'b0;
    end else if (start_det) begin
      // repeated start keeps hs mode and the channel pointer
      state <= ST_ADDR;
      bitcnt <= 4'h0;
      have_upper <= 1'b0;
      ack_phase <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (stop_det) begin
      state <= ST_IDLE;
      have_upper <= 1'b0;
      ack_phase <= 1'b0;
      o_sda_oe <= 1'b0;
      o_hs_mode <= 1'b0;
    end else begin
      // latch pin low: the output bank tracks the whole preload bank
      if (!latch_hold_sync)
        o_level <= preload;
      if (scl_rise && state != ST_IDLE) begin
        if (ack_phase)
          master_ack <= ~sda;
        else begin
          // while reading, shreg holds the outgoing byte; never shift it here
          if (state != ST_RDATA)
            shreg <= rx_next;
          bitcnt <= bitcnt + 4'h1;
        end
      end
      if (scl_fall && state != ST_IDLE) begin
        if (ack_phase) begin
          // end of ninth clock: release sda, set up next byte
          ack_phase <= 1'b0;
          bitcnt <= 4'h0;
          o_sda_oe <= 1'b0;
          if (state == ST_RDATA) begin
            if (!master_ack)
              state <= ST_IGNORE; // master nack ends the read
            else begin
              o_sda_oe <= ~tx_byte[7];
              shreg <= {tx_byte[6:0], 1'b0};
            end
          end
        end else if (bitcnt == 4'h8) begin
          ack_phase <= 1'b1;
          o_sda_oe <= 1'b0;
          case (state)
            ST_ADDR: begin
              // the master code is never acked and opens hs operation
              if (is_master_code && !o_hs_mode) begin
                o_hs_mode <= 1'b1;
                state <= ST_IGNORE;
              end else if (is_gcall) begin
                o_sda_oe <= 1'b1;
                state <= ST_GCALL;
              end else if (is_own) begin
                o_sda_oe <= 1'b1;
                if (is_read) begin
                  // the first read byte is the high half of the word
                  state <= ST_RDATA;
                  tx_byte <= rd_hi;
                  tx_low <= 1'b0;
                end else
                  state <= ST_CMD;
              end else
                state <= ST_IGNORE;
            end
            ST_CMD: begin
              // a refused channel byte is nacked, so no data follows it
              chan <= rx_byte[3:0];
              if (chan_byte_ok) begin
                o_sda_oe <= 1'b1;
                state <= ST_WDATA;
              end else
                state <= ST_IGNORE;
            end
            ST_GCALL: begin
              if (rx_byte == `GDT_GCALL_RESET)
                o_sda_oe <= 1'b1;
              state <= ST_IGNORE;
            end
            ST_WDATA: begin
              if (!chan_ok)
                state <= ST_IGNORE;
              else if (!have_upper) begin
                // the high half waits here; a start or stop drops it
                upper <= rx_byte;
                have_upper <= 1'b1;
                o_sda_oe <= 1'b1;
              end else begin
                have_upper <= 1'b0;
                o_sda_oe <= 1'b1;
                preload[chan*10 +: 10] <= wr_code;
                chan <= chan + 4'h1;
                if (!latch_hold_sync)
                  o_level[chan*10 +: 10] <= wr_code;
                else if (latch_all) begin
                  // the whole bank moves at once, this word included
                  o_level <= preload;
                  o_level[chan*10 +: 10] <= wr_code;
                end
              end
            end
            ST_RDATA: begin
              // line released for the master's ack; the read goes on
              state <= ST_RDATA;
            end
            default: state <= ST_IGNORE;
          endcase
        end else if (state == ST_RDATA) begin
          // shift the next read bit out; a 1 releases the line
          o_sda_oe <= ~shreg[7];
          shreg <= {shreg[6:0], 1'b0};
        end
      end
      // ack of general call reset done: reset on release of the line
      if (scl_fall && ack_phase && state == ST_IGNORE && o_sda_oe && shreg == `GDT_GCALL_RESET)
        gcall_rst <= 1'b1;
      // queue the byte after the one just launched: the low half of the same
      // channel, or the high half of the next one once a word is done
      if (scl_fall && ack_phase && state == ST_RDATA && master_ack) begin
        if (!tx_low) begin
          tx_byte <= rd_lo;
          tx_low <= 1'b1;
        end else begin
          chan <= next_chan;
          tx_byte <= nxt_hi;
          tx_low <= 1'b0;
        end
      end
    end
  end

endmodule

// two-flop synchroniser for one pin; only the second stage leaves it,
// so the possibly metastable first stage never reaches any logic
module gdt_sync2 #(
  parameter RST_VAL = 1'b0
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_pin,
  output reg o_sync
);

  reg meta;

  // reset value matches the pin's idle level to avoid a false edge
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta <= i_pin;
      o_sync <= meta;
    end
  end

endmodule

`default_nettype wire

// ---- shared/gdt_regs.vh ----
/*
  constants for the two-wire slave of the 12-channel reference generator:
  addresses, command codes, channel index range, reset codes.
  assumes inclusion by bare name from design files.
*/
`ifndef GDT_REGS_VH
`define GDT_REGS_VH

`define GDT_ADDR_BASE 6'h3a
`define GDT_GCALL_ADDR 8'h00
`define GDT_GCALL_RESET 8'h06
`define GDT_HS_CODE_TOP 5'h01
`define GDT_CHAN_LAST 4'hb
`define GDT_CODE_MSB 9
`define GDT_LATCH_ALL_BIT 15
`define GDT_RST_A 10'h3e0
`define GDT_RST_B 10'h360
`define GDT_RST_C 10'h320
`define GDT_RST_D 10'h300
`define GDT_RST_E 10'h2c0
`define GDT_RST_F 10'h240
`define GDT_RST_G 10'h1c0
`define GDT_RST_H 10'h140
`define GDT_RST_I 10'h100
`define GDT_RST_J 10'h0e0
`define GDT_RST_K 10'h0a0
`define GDT_RST_L 10'h020

`endif

// ---- test/gamma_dac_two_wire_slave_test.sv ----
/* bench for the two-wire slave: scenarios, master model, checker bind.
   assumes sda has a pull-up; scl period about 120 ns. */
`timescale 1ns/10ps
`default_nettype none
`include "gdt_regs.vh"
module gamma_dac_two_wire_slave_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic addr_select_pin = 1'b0;
  logic latch_hold_pin = 1'b0;
  logic ak;
  logic [7:0] q;
  int failures = 0;
  int check_count = 0;
  wire scl;
  wire sda_low;
  wire sda_oe;
  wire hs;
  wire [119:0] level;
  wire sda = ~(sda_low | sda_oe);
  always #5 clk = ~clk;
  gdt_bus_master u_m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  gdt_slave u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda),
    .i_addr_select_pin(addr_select_pin), .i_latch_hold_pin(latch_hold_pin),
    .o_sda_oe(sda_oe), .o_hs_mode(hs), .o_level(level));
  task automatic chk(input logic [119:0] g, input logic [119:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // items are {expected ack, byte}
  task automatic tx(input logic [8:0] b[$], input logic stp);
    u_m.st;
    foreach (b[i]) begin
      u_m.x(b[i][7:0], 1'b1, q, ak);
      chk(ak, b[i][8]);
    end
    if (stp) u_m.sp;
  endtask
  // items are {master nack, expected byte}
  task automatic rx(input logic [8:0] b[$]);
    foreach (b[i]) begin
      u_m.x(8'hff, b[i][8], q, ak);
      chk(q, b[i][7:0]);
    end
    u_m.sp;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_write;
    tx('{9'h1e8, 9'h10a, 9'h101, 9'h111, 9'h102, 9'h15a}, 1'b1);
    chk(level[119:100], {10'h25a, 10'h111});
    tx('{9'h1e8, 9'h00c}, 1'b1);
    $display("write test done");
  endtask
  task automatic t_read;
    tx('{9'h1e8, 9'h10b}, 1'b0);
    tx('{9'h1e9}, 1'b0);
    rx('{9'h002, 9'h05a, 9'h003, 9'h1e0});
    $display("read test done");
  endtask
  task automatic t_latch;
    latch_hold_pin <= 1'b1;
    tx('{9'h1e8, 9'h100, 9'h101, 9'h123}, 1'b1);
    tx('{9'h1e8, 9'h102, 9'h181}, 1'b1);
    chk(level[29:0], {`GDT_RST_C, `GDT_RST_B, `GDT_RST_A});
    tx('{9'h1e8, 9'h101, 9'h180, 9'h144}, 1'b1);
    chk(level[29:0], {`GDT_RST_C, 10'h044, 10'h123});
    latch_hold_pin <= 1'b0;
    $display("latch test done");
  endtask
  task automatic t_hs;
    tx('{9'h00d}, 1'b0);
    chk(hs, 1'b1);
    tx('{9'h1e8}, 1'b0);
    chk(hs, 1'b1);
    u_m.sp;
    chk(hs, 1'b0);
    $display("hs test done");
  endtask
  task automatic t_gc;
    tx('{9'h100, 9'h005}, 1'b1);
    chk(level[9:0], 10'h123);
    tx('{9'h100, 9'h106}, 1'b1);
    chk({level[119:110], level[9:0]}, {`GDT_RST_L, `GDT_RST_A});
    $display("general call test done");
  endtask
  task automatic t_asel;
    addr_select_pin <= 1'b1;
    tx('{9'h0e8}, 1'b1);
    tx('{9'h1ea}, 1'b1);
    addr_select_pin <= 1'b0;
    $display("address select test done");
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk({level[119:110], level[9:0], sda_oe, hs}, {`GDT_RST_L, `GDT_RST_A, 2'b00});
    t_write;
    t_read;
    t_latch;
    t_hs;
    t_gc;
    t_asel;
    report_and_stop;
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    report_and_stop;
  end
endmodule
bind gdt_slave gdt_slave_sva #(.NCH(NCH)) u_sva (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(i_scl),
  .i_sda(i_sda), .i_addr_select_pin(i_addr_select_pin), .i_latch_hold_pin(i_latch_hold_pin),
  .o_sda_oe(o_sda_oe), .o_hs_mode(o_hs_mode), .o_level(o_level));
`default_nettype wire

// ---- test/gdt_bus_master.sv ----
/* two-wire master model: drives scl, pulls sda low.
   assumes a pull-up on sda in the bench. */
`timescale 1ns/10ps
`default_nettype none
module gdt_bus_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // bus idles released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // start or repeated start; waits first so sda never moves with scl
  task automatic st;
    w(3);
    o_sda_low <= 1'b0;
    w(3);
    o_scl <= 1'b1;
    w(6);
    o_sda_low <= 1'b1;
    w(6);
    o_scl <= 1'b0;
  endtask
  task automatic sp;
    w(3);
    o_sda_low <= 1'b1;
    w(3);
    o_scl <= 1'b1;
    w(6);
    o_sda_low <= 1'b0;
    w(6);
  endtask
  // eight bits msb first then the ninth; ma high releases the ninth
  task automatic x(input logic [7:0] d, input logic ma, output logic [7:0] q, output logic ak);
    logic [8:0] v;
    logic [8:0] s;
    v = {d, ma};
    for (int i = 8; i >= 0; i--) begin
      w(3);
      o_sda_low <= ~v[i];
      w(3);
      o_scl <= 1'b1;
      w(6);
      s[i] = i_sda;
      o_scl <= 1'b0;
    end
    q = s[8:1];
    ak = ~s[0];
  endtask
endmodule
`default_nettype wire

// ---- test/gdt_slave_sva.sv ----
/* port assertions for the two-wire slave.
   assumes binding to gdt_slave with sda resolved outside. */
`timescale 1ns/10ps
`default_nettype none
`include "gdt_regs.vh"
module gdt_slave_sva #(
  parameter NCH = 12
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_addr_select_pin,
  input wire logic i_latch_hold_pin,
  input wire logic o_sda_oe,
  input wire logic o_hs_mode,
  input wire logic [NCH*10-1:0] o_level
);
  default clocking @(posedge i_clk); endclocking
  // reset loads fixed codes and quiets the pins
  property p_rst_lvl; !i_reset_n |=> o_level[9:0] == `GDT_RST_A && o_level[119:110] == `GDT_RST_L; endproperty
  a_rst_lvl: assert property (p_rst_lvl) else $error("reset level wrong");
  property p_rst_out; !i_reset_n |=> !o_sda_oe && !o_hs_mode; endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset outputs wrong");
  // sda drive moves only while scl is low, so no false start or stop
  property p_oe_rise; disable iff (!i_reset_n) $rose(o_sda_oe) |-> !i_scl; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive rose with scl high");
  property p_oe_fall; disable iff (!i_reset_n) $fell(o_sda_oe) |-> !i_scl; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("drive fell with scl high");
  property p_oe_hold; disable iff (!i_reset_n) o_sda_oe && i_scl |=> o_sda_oe; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("ack dropped early");
  // hs entry is never acked, survives repeated starts, ends at stop
  property p_hs_ack; disable iff (!i_reset_n) $rose(o_hs_mode) |-> !o_sda_oe [*8]; endproperty
  a_hs_ack: assert property (p_hs_ack) else $error("master code acked");
  property p_hs_keep; disable iff (!i_reset_n) o_hs_mode && !(i_scl && i_sda) |=> o_hs_mode; endproperty
  a_hs_keep: assert property (p_hs_keep) else $error("hs left without stop");
  property p_hs_exit; disable iff (!i_reset_n) o_hs_mode && i_scl && $rose(i_sda) |-> ##[1:6] !o_hs_mode; endproperty
  a_hs_exit: assert property (p_hs_exit) else $error("hs kept after stop");
endmodule
`default_nettype wire
